// file: common/acqctl_pkg.sv
// Package for the acquisition mode and stop control block.
// Assumes one 25 MHz clock and a plain register port on the owning module.
package acqctl_pkg;

   // =====================================================================
   // Register map (word index = byte address / 4)
   localparam logic [7:0]  ADDR_MODE      = 8'h00;
   localparam logic [7:0]  ADDR_COUNT     = 8'h04;
   localparam logic [7:0]  ADDR_RECLEN    = 8'h08;
   localparam logic [7:0]  ADDR_TIMEBASE  = 8'h0C;
   localparam logic [7:0]  ADDR_DISPLAY   = 8'h10;
   localparam logic [7:0]  ADDR_PERSIST   = 8'h14;
   localparam logic [7:0]  ADDR_INTENS    = 8'h18;
   localparam logic [7:0]  ADDR_STATUS    = 8'h1C;
   localparam logic [7:0]  ADDR_ACQCNT    = 8'h20;

   // =====================================================================
   // Field positions in the mode register
   localparam int MODE_ACQ_LSB   = 0;
   localparam int MODE_STOP_LSB  = 4;
   localparam int MODE_REP_BIT   = 8;
   localparam int MODE_LIMEN_BIT = 9;
   localparam int MODE_SINC_BIT  = 10;
   localparam int MODE_CH_LSB    = 12;

   // Display register fields
   localparam int DISP_STYLE_LSB = 0;
   localparam int DISP_ZOOM_LSB  = 4;

   // =====================================================================
   // Limits and reset values
   localparam logic [23:0] HIRES_REC_LIMIT = 24'h07A120;  // 500000 points
   localparam logic [23:0] RECLEN_RST      = 24'h0003E8;
   localparam logic [15:0] AVG_COUNT_RST   = 16'h0010;
   localparam logic [6:0]  INTENS_MIN      = 7'h14;        // 20 percent
   localparam logic [6:0]  INTENS_MAX      = 7'h64;        // 100 percent
   localparam logic [6:0]  INTENS_RST      = 7'h64;
   localparam logic [7:0]  ZOOM_UNITY      = 8'h01;

   // Time base thresholds, ns per division
   localparam logic [31:0] TB_REAL_NS      = 32'h0000_0064;  // 100 ns
   localparam logic [31:0] TB_MID_NS       = 32'h0000_0032;  // 50 ns
   localparam logic [31:0] TB_FAST_NS      = 32'h0000_0019;  // 25 ns

   // Persistence time unit: 1 ms
   localparam int CLK_HZ         = 25_000_000;
   localparam int PERSIST_UNIT_US = 1000;
   localparam int PERSIST_TICK_CYC = CLK_HZ / 1_000_000 * PERSIST_UNIT_US;

   // =====================================================================
   typedef enum logic [2:0] {
      ACQ_SAMPLE  = 3'h0,
      ACQ_EXTREME = 3'h1,
      ACQ_HIRES   = 3'h2,
      ACQ_ENVEL   = 3'h3,
      ACQ_AVERAGE = 3'h4
   } acqctl_mode_t;

   typedef enum logic [1:0] {
      STOP_RUNHALT = 2'h0,
      STOP_SINGLE  = 2'h1,
      STOP_LIMIT   = 2'h2
   } acqctl_stop_t;

   typedef enum logic [1:0] {
      SMP_REAL   = 2'h0,
      SMP_EQUIV  = 2'h1,
      SMP_INTERP = 2'h2
   } acqctl_smp_t;

   typedef enum logic [2:0] {
      STY_VECTORS = 3'h0,
      STY_INTENS  = 3'h1,
      STY_DOTS    = 3'h2,
      STY_INFPER  = 3'h3,
      STY_VARPER  = 3'h4
   } acqctl_style_t;

   // Front-panel and trigger events arriving each cycle
   typedef struct packed {
      logic run_halt_press;
      logic shifted_force_trigger_press;
      logic trigger;
      logic record_filled;
      logic limit_violation;
      logic setting_changed;
   } acqctl_evt_t;

   // Acquisition control outputs
   typedef struct packed {
      logic          acquiring;
      acqctl_mode_t  eff_mode;
      acqctl_smp_t   smp;
      logic          interp_sinc;
      logic          capture;
      logic          env_track;
      logic          first_sample;
   } acqctl_ctl_t;

endpackage : acqctl_pkg

// file: src/acqctl_top.sv
// Acquisition mode, sampling choice, stop control and display settings.
// Assumes panel and trigger events are one-cycle pulses on sys_clk.
//
// Function
// - Hold acquisition count for envelope or average
// - Clamp record length entering high resolution
// - Repetitive on: real or equivalent time
// - Repetitive off: real time, interpolate gaps
// - Real at 100ns+, faster than 25ns not
// - 50ns real up to two, 25ns one
// - Fill gaps with selected interpolation filter
// - Run/halt toggles; stopped shows acquisition count
// - Single sequence: one record then stop
// - Single sequence, envelope or average: configured count then stop
// - Equivalent-time single: run until record filled
// - Shifted force trigger selects single sequence
// - Limit mode: halt on limit violation
// - Limit stop only when limit testing enabled
// - Intensified samples only interpolating or zoomed
// - Variable persistence keeps points entered time
// - Infinite persistence erased on setting change
// - Two intensities confined to 20..100 percent
// - Extreme pair single, envelope across acquisitions
// - High resolution and extreme fall back to sample when not real
// - Sample mode keeps first sample per interval
`timescale 1ns/100ps
module acqctl_top
   import acqctl_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire acqctl_evt_t evt,
   output acqctl_ctl_t      ctl,
   output logic             persist_expire,
   output logic             persist_erase,
   output logic             intens_sample_mark,
   output logic      [6:0]  text_intensity,
   output logic      [6:0]  wave_intensity
);

   // ======================================================================
   // Configuration registers
   acqctl_mode_t  acq_mode_r;
   acqctl_stop_t  stop_mode_r;
   logic          rep_on_r;
   logic          limit_en_r;
   logic          sinc_r;
   logic [2:0]    chan_cnt_r;
   logic [15:0]   acq_count_r;
   logic [23:0]   reclen_r;
   logic [31:0]   timebase_r;
   acqctl_style_t style_r;
   logic [7:0]    zoom_r;
   logic [15:0]   persist_time_r;
   logic          acquiring_r;
   logic [31:0]   acqcnt_r;
   logic [15:0]   seq_cnt_r;
   logic [31:0]   rdata_r;
   logic [15:0]   persist_age_r;
   logic [$clog2(PERSIST_TICK_CYC)-1:0] tick_cnt_r;

   wire wr_mode    = reg_wr && reg_addr == ADDR_MODE;
   wire wr_count   = reg_wr && reg_addr == ADDR_COUNT;
   wire wr_reclen  = reg_wr && reg_addr == ADDR_RECLEN;
   wire wr_tb      = reg_wr && reg_addr == ADDR_TIMEBASE;
   wire wr_disp    = reg_wr && reg_addr == ADDR_DISPLAY;
   wire wr_persist = reg_wr && reg_addr == ADDR_PERSIST;
   wire wr_intens  = reg_wr && reg_addr == ADDR_INTENS;

   wire [2:0] new_acq  = reg_wdata[MODE_ACQ_LSB +: 3];
   wire [1:0] new_stop = reg_wdata[MODE_STOP_LSB +: 2];
   wire       new_acq_ok  = new_acq <= 3'h4;
   wire       new_stop_ok = new_stop <= 2'h2;
   wire       enter_hires = wr_mode && new_acq_ok && new_acq == ACQ_HIRES;

   // Clamp applies to whichever record length will stand after this cycle
   wire [23:0] reclen_src = wr_reclen ? reg_wdata[23:0] : reclen_r;
   wire        hires_next = enter_hires || (acq_mode_r == ACQ_HIRES && !wr_mode);
   wire [23:0] reclen_nxt = (hires_next && reclen_src > HIRES_REC_LIMIT)
                            ? HIRES_REC_LIMIT : reclen_src;

   // Intensity saturates into range rather than rejecting the write
   function automatic logic [6:0] clamp_int(input logic [7:0] v);
      if (v < {1'b0, INTENS_MIN})
         return INTENS_MIN;
      else if (v > {1'b0, INTENS_MAX})
         return INTENS_MAX;
      else
         return v[6:0];
   endfunction : clamp_int

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         acq_mode_r     <= ACQ_SAMPLE;
         stop_mode_r    <= STOP_RUNHALT;
         rep_on_r       <= 1'b0;
         limit_en_r     <= 1'b0;
         sinc_r         <= 1'b1;
         chan_cnt_r     <= 3'h1;
         acq_count_r    <= AVG_COUNT_RST;
         reclen_r       <= RECLEN_RST;
         timebase_r     <= TB_REAL_NS;
         style_r        <= STY_VECTORS;
         zoom_r         <= ZOOM_UNITY;
         persist_time_r <= 16'h0001;
         text_intensity <= INTENS_RST;
         wave_intensity <= INTENS_RST;
      end
      else
      begin
         if (wr_mode)
         begin
            if (new_acq_ok)
               acq_mode_r <= acqctl_mode_t'(new_acq);
            if (new_stop_ok)
               stop_mode_r <= acqctl_stop_t'(new_stop);
            rep_on_r   <= reg_wdata[MODE_REP_BIT];
            limit_en_r <= reg_wdata[MODE_LIMEN_BIT];
            sinc_r     <= reg_wdata[MODE_SINC_BIT];
            chan_cnt_r <= reg_wdata[MODE_CH_LSB +: 3];
         end
         else if (evt.shifted_force_trigger_press)
            stop_mode_r <= STOP_SINGLE;
         if (wr_count && reg_wdata[15:0] != 16'h0000)
            acq_count_r <= reg_wdata[15:0];
         reclen_r <= reclen_nxt;
         if (wr_tb)
            timebase_r <= reg_wdata;
         if (wr_disp)
         begin
            if (reg_wdata[DISP_STYLE_LSB +: 3] <= 3'h4)
               style_r <= acqctl_style_t'(reg_wdata[DISP_STYLE_LSB +: 3]);
            zoom_r <= reg_wdata[DISP_ZOOM_LSB +: 8];
         end
         if (wr_persist && reg_wdata[15:0] != 16'h0000)
            persist_time_r <= reg_wdata[15:0];
         if (wr_intens)
         begin
            text_intensity <= clamp_int(reg_wdata[7:0]);
            wave_intensity <= clamp_int(reg_wdata[15:8]);
         end
      end
   end

   // ======================================================================
   // Sampling method from time base and channel count
   wire tb_slow  = timebase_r >= TB_REAL_NS;
   wire tb_mid   = timebase_r >= TB_MID_NS && chan_cnt_r <= 3'h2;
   wire tb_fast  = timebase_r >= TB_FAST_NS && chan_cnt_r <= 3'h1;
   wire real_ok  = tb_slow || tb_mid || tb_fast;
   // Equivalent time only when repetitive signal allowed, else interpolate
   wire [1:0] smp_sel = real_ok ? SMP_REAL :
                        rep_on_r ? SMP_EQUIV : SMP_INTERP;
   wire not_real = smp_sel != SMP_REAL;
   // Menu selection kept; only the effective mode drops back
   wire fallback = not_real && (acq_mode_r == ACQ_HIRES || acq_mode_r == ACQ_EXTREME);
   wire [2:0] eff_mode = fallback ? ACQ_SAMPLE : acq_mode_r;
   wire multi_acq = acq_mode_r == ACQ_ENVEL || acq_mode_r == ACQ_AVERAGE;

   // ======================================================================
   // Stop control
   wire limit_hit   = stop_mode_r == STOP_LIMIT && limit_en_r
                      && evt.limit_violation;
   wire seq_done_et = smp_sel == SMP_EQUIV && evt.record_filled;
   wire seq_last    = multi_acq ? seq_cnt_r + 16'h0001 >= acq_count_r : 1'b1;
   wire seq_done_rt = smp_sel != SMP_EQUIV && evt.trigger && seq_last;
   wire single_stop = stop_mode_r == STOP_SINGLE && (seq_done_et || seq_done_rt);
   wire start       = !acquiring_r && evt.run_halt_press;
   wire halt        = acquiring_r && (evt.run_halt_press || single_stop || limit_hit);
   wire acq_done    = acquiring_r && (smp_sel == SMP_EQUIV ? evt.record_filled
                                                           : evt.trigger);

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         acquiring_r <= 1'b0;
         acqcnt_r    <= 32'h0000_0000;
         seq_cnt_r   <= 16'h0000;
      end
      else
      begin
         if (start)
            acquiring_r <= 1'b1;
         else if (halt)
            acquiring_r <= 1'b0;
         if (start)
         begin
            acqcnt_r  <= 32'h0000_0000;
            seq_cnt_r <= 16'h0000;
         end
         else if (acq_done)
         begin
            acqcnt_r  <= acqcnt_r + 32'h0000_0001;
            seq_cnt_r <= seq_cnt_r + 16'h0001;
         end
      end
   end

   // ======================================================================
   // Persistence timing, one tick per unit of persistence time
   wire tick = tick_cnt_r == ($clog2(PERSIST_TICK_CYC))'(PERSIST_TICK_CYC - 1);
   wire age_full = persist_age_r + 16'h0001 >= persist_time_r;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         tick_cnt_r     <= '0;
         persist_age_r  <= 16'h0000;
         persist_expire <= 1'b0;
         persist_erase  <= 1'b0;
      end
      else
      begin
         tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
         persist_expire <= 1'b0;
         if (style_r == STY_VARPER && tick)
         begin
            persist_age_r  <= age_full ? 16'h0000 : persist_age_r + 16'h0001;
            persist_expire <= age_full;
         end
         // Erase only on a real control change, never on time
         persist_erase <= style_r == STY_INFPER && evt.setting_changed;
      end
   end

   // ======================================================================
   // Control outputs, all registered
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         ctl                <= '0;
         intens_sample_mark <= 1'b0;
      end
      else
      begin
         ctl.acquiring    <= acquiring_r;
         ctl.eff_mode     <= acqctl_mode_t'(eff_mode);
         ctl.smp          <= acqctl_smp_t'(smp_sel);
         ctl.interp_sinc  <= sinc_r;
         ctl.capture      <= acquiring_r && evt.trigger;
         ctl.env_track    <= acq_mode_r == ACQ_ENVEL;
         ctl.first_sample <= eff_mode == ACQ_SAMPLE;
         intens_sample_mark <= style_r == STY_INTENS &&
                               ((smp_sel == SMP_INTERP && !rep_on_r) ||
                                zoom_r > ZOOM_UNITY);
      end
   end

   // ======================================================================
   // Register read port, data one cycle after the strobe
   wire [31:0] mode_rd = {17'h0, chan_cnt_r, 1'b0, sinc_r, limit_en_r, rep_on_r,
                          2'h0, stop_mode_r, 1'b0, acq_mode_r};
   wire [31:0] status_rd = {25'h0, acq_mode_r == ACQ_HIRES, fallback,
                            stop_mode_r, smp_sel, acquiring_r};
   wire [31:0] rd_mux =
      reg_addr == ADDR_MODE     ? mode_rd :
      reg_addr == ADDR_COUNT    ? {16'h0, acq_count_r} :
      reg_addr == ADDR_RECLEN   ? {8'h0, reclen_r} :
      reg_addr == ADDR_TIMEBASE ? timebase_r :
      reg_addr == ADDR_DISPLAY  ? {20'h0, zoom_r, 1'b0, style_r} :
      reg_addr == ADDR_PERSIST  ? {16'h0, persist_time_r} :
      reg_addr == ADDR_INTENS   ? {17'h0, wave_intensity, 1'b0, text_intensity} :
      reg_addr == ADDR_STATUS   ? status_rd :
      reg_addr == ADDR_ACQCNT   ? acqcnt_r : 32'h0000_0000;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
         rdata_r <= 32'h0000_0000;
      else
         rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
   end
   assign reg_rdata = rdata_r;

   // ======================================================================
   // Checks
   property p_hires_clamp;
      @(posedge sys_clk) disable iff (srst)
      enter_hires |=> reclen_r <= HIRES_REC_LIMIT;
   endproperty
   a_hires_clamp: assert property (p_hires_clamp) else $error("record length not clamped");

   property p_slow_real;
      @(posedge sys_clk) disable iff (srst)
      tb_slow |=> ctl.smp == SMP_REAL || $changed(timebase_r);
   endproperty
   a_slow_real: assert property (p_slow_real) else $error("slow time base not real");

   property p_no_et_when_off;
      @(posedge sys_clk) disable iff (srst)
      !rep_on_r |=> ctl.smp != SMP_EQUIV || $changed(rep_on_r);
   endproperty
   a_no_et_when_off: assert property (p_no_et_when_off) else $error("ET used while off");

   property p_toggle;
      @(posedge sys_clk) disable iff (srst)
      evt.run_halt_press && stop_mode_r == STOP_RUNHALT |=> acquiring_r != $past(acquiring_r);
   endproperty
   a_toggle: assert property (p_toggle) else $error("run halt did not toggle");

   property p_single_stop;
      @(posedge sys_clk) disable iff (srst)
      acquiring_r && stop_mode_r == STOP_SINGLE && !multi_acq && smp_sel == SMP_REAL
         && evt.trigger |=> !acquiring_r;
   endproperty
   a_single_stop: assert property (p_single_stop) else $error("single did not stop");

   property p_limit_gate;
      @(posedge sys_clk) disable iff (srst)
      acquiring_r && !limit_en_r && !evt.run_halt_press && stop_mode_r == STOP_LIMIT
         |=> acquiring_r;
   endproperty
   a_limit_gate: assert property (p_limit_gate) else $error("limit stop while disabled");

   property p_force_single;
      @(posedge sys_clk) disable iff (srst)
      evt.shifted_force_trigger_press && !wr_mode |=> stop_mode_r == STOP_SINGLE;
   endproperty
   a_force_single: assert property (p_force_single) else $error("force not single");

   property p_restart_clear;
      @(posedge sys_clk) disable iff (srst)
      start |=> acqcnt_r == 32'h0000_0000 ##1 acqcnt_r <= 32'h0000_0001;
   endproperty
   a_restart_clear: assert property (p_restart_clear) else $error("count not cleared");

   property p_intens_range;
      @(posedge sys_clk) disable iff (srst)
      wr_intens |=> text_intensity >= INTENS_MIN && text_intensity <= INTENS_MAX
                    && wave_intensity >= INTENS_MIN && wave_intensity <= INTENS_MAX;
   endproperty
   a_intens_range: assert property (p_intens_range) else $error("intensity out of range");

   property p_et_hold;
      @(posedge sys_clk) disable iff (srst)
      acquiring_r && stop_mode_r == STOP_SINGLE && smp_sel == SMP_EQUIV
         && !evt.record_filled && !evt.run_halt_press |=> acquiring_r;
   endproperty
   a_et_hold: assert property (p_et_hold) else $error("ET single stopped early");

   property p_expire_gate;
      @(posedge sys_clk) disable iff (srst)
      style_r != STY_VARPER |=> !persist_expire;
   endproperty
   a_expire_gate: assert property (p_expire_gate) else $error("stray expire");

   property p_mark_gate;
      @(posedge sys_clk) disable iff (srst)
      style_r != STY_INTENS |=> !intens_sample_mark;
   endproperty
   a_mark_gate: assert property (p_mark_gate) else $error("stray sample mark");

   property p_erase_gate;
      @(posedge sys_clk) disable iff (srst)
      !evt.setting_changed |=> !persist_erase;
   endproperty
   a_erase_gate: assert property (p_erase_gate) else $error("erase without change");

   property p_env_track;
      @(posedge sys_clk) disable iff (srst)
      acq_mode_r == ACQ_ENVEL |=> ctl.env_track;
   endproperty
   a_env_track: assert property (p_env_track) else $error("envelope not tracked");

endmodule : acqctl_top

// file: verification/acqctl_panel_model.sv
// Front-panel and trigger source model facing the acquisition control block.
// Assumes the bench asks for events one cycle at a time on sys_clk.
`timescale 1ns/100ps
module acqctl_panel_model
   import acqctl_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic [5:0]  ask,
   input  wire logic        slow,
   output acqctl_evt_t      evt
);
   // ======================================================================
   // Event launch
   logic [5:0] stage_r;

   // Slow path models a panel scanner that reports one cycle late
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         stage_r <= 6'h00;
         evt     <= '0;
      end
      else
      begin
         stage_r <= ask;
         evt     <= slow ? acqctl_evt_t'(stage_r) : acqctl_evt_t'(ask);
      end
   end
endmodule : acqctl_panel_model

// file: verification/acqctl_top_test.sv
// Self-checking bench for the acquisition mode and stop control block.
// Assumes the panel model file is compiled before this one.
`timescale 1ns/100ps
module acqctl_top_test
   import acqctl_pkg::*;
;
   logic              sys_clk   = 1'b0;
   logic              srst      = 1'b1;
   logic [7:0]        reg_addr  = 8'h00;
   logic [31:0]       reg_wdata = 32'h0;
   logic              reg_wr    = 1'b0;
   logic              reg_rd    = 1'b0;
   logic [31:0]       reg_rdata;
   logic [5:0]        ask       = 6'h00;
   logic              slow      = 1'b0;
   acqctl_evt_t       evt;
   acqctl_ctl_t       ctl;
   logic              persist_expire;
   logic              persist_erase;
   logic              intens_sample_mark;
   logic [6:0]        text_intensity;
   logic [6:0]        wave_intensity;
   int                bad_count = 0;
   int                n_checks  = 0;
   int                erase_seen = 0;
   int                expire_seen = 0;
   int                capture_seen = 0;
   logic [31:0]       rv;

   always #20 sys_clk = ~sys_clk;

   acqctl_top i_acqctl_top (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .evt(evt), .ctl(ctl), .persist_expire(persist_expire), .persist_erase(persist_erase),
      .intens_sample_mark(intens_sample_mark), .text_intensity(text_intensity),
      .wave_intensity(wave_intensity));

   acqctl_panel_model i_acqctl_panel_model (.sys_clk(sys_clk), .srst(srst), .ask(ask),
      .slow(slow), .evt(evt));

   always @(posedge sys_clk)
   begin
      if (persist_erase === 1'b1) erase_seen++;
      if (persist_expire === 1'b1) expire_seen++;
      if (ctl.capture === 1'b1) capture_seen++;
   end

   // ======================================================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   task automatic settle();
      repeat (5) @(posedge sys_clk);
      #1;
   endtask : settle

   // Bits: 5 run/halt, 4 shifted force, 3 trigger, 2 filled, 1 limit, 0 setting
   task automatic pulse(input int b, input int n);
      repeat (n)
      begin
         @(posedge sys_clk);
         ask <= 6'(1 << b);
         @(posedge sys_clk);
         ask <= 6'h00;
      end
      settle();
   endtask : pulse

   function automatic logic [31:0] mw(input logic [2:0] acq, input logic [1:0] stp,
      input logic rep, input logic lim, input logic [2:0] ch);
      mw = {17'h0, ch, 1'b0, 1'b1, lim, rep, 2'b00, stp, 1'b0, acq};
   endfunction : mw

   function automatic logic [31:0] acq_now();
      acq_now = {31'h0, ctl.acquiring};
   endfunction : acq_now

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   // ======================================================================
   // Scenarios
   task automatic t_reset();
      chk({25'h0, text_intensity}, 32'h64);
      chk({25'h0, wave_intensity}, 32'h64);
      rd(ADDR_MODE, rv);
      chk(rv, 32'h1400);
      rd(ADDR_COUNT, rv);
      chk(rv, 32'h10);
      wr(8'h40, 32'h5);
      rd(8'h40, rv);
      chk(rv, 32'h0);
      wr(ADDR_COUNT, 32'h5);
      wr(ADDR_COUNT, 32'h0);
      rd(ADDR_COUNT, rv);
      chk(rv, 32'h5);
      $display("reset and count test done");
   endtask : t_reset

   task automatic t_sampling();
      logic [31:0] tb  [7] = '{32'h64, 32'h32, 32'h32, 32'h19, 32'h19, 32'h0A, 32'h0A};
      logic [2:0]  ch  [7] = '{3'h4, 3'h2, 3'h3, 3'h1, 3'h2, 3'h1, 3'h1};
      logic        rep [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
      logic [1:0]  exp [7] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h2, 2'h1};
      for (int i = 0; i < 7; i++)
      begin
         wr(ADDR_TIMEBASE, tb[i]);
         wr(ADDR_MODE, mw(ACQ_SAMPLE, STOP_RUNHALT, rep[i], 1'b0, ch[i]));
         settle();
         chk({30'h0, ctl.smp}, {30'h0, exp[i]});
      end
      wr(ADDR_MODE, mw(ACQ_HIRES, STOP_RUNHALT, 1'b0, 1'b0, 3'h1) & 32'hFFFF_FBFF);
      settle();
      chk({29'h0, ctl.eff_mode}, {29'h0, ACQ_SAMPLE});
      chk({31'h0, ctl.interp_sinc}, 32'h0);
      chk({31'h0, ctl.first_sample}, 32'h1);
      rd(ADDR_MODE, rv);
      chk(rv & 32'h7, 32'h2);
      wr(ADDR_MODE, mw(ACQ_EXTREME, STOP_RUNHALT, 1'b0, 1'b0, 3'h1));
      settle();
      chk({29'h0, ctl.eff_mode}, {29'h0, ACQ_SAMPLE});
      chk({31'h0, ctl.interp_sinc}, 32'h1);
      wr(ADDR_TIMEBASE, 32'h64);
      settle();
      chk({29'h0, ctl.eff_mode}, {29'h0, ACQ_EXTREME});
      chk({31'h0, ctl.first_sample}, 32'h0);
      wr(ADDR_MODE, mw(ACQ_ENVEL, STOP_RUNHALT, 1'b0, 1'b0, 3'h1));
      settle();
      chk({31'h0, ctl.env_track}, 32'h1);
      $display("sampling choice test done");
   endtask : t_sampling

   task automatic t_clamp();
      wr(ADDR_MODE, mw(ACQ_SAMPLE, STOP_RUNHALT, 1'b0, 1'b0, 3'h1));
      wr(ADDR_RECLEN, 32'h0009_27C0);
      rd(ADDR_RECLEN, rv);
      chk(rv, 32'h0009_27C0);
      wr(ADDR_MODE, mw(ACQ_HIRES, STOP_RUNHALT, 1'b0, 1'b0, 3'h1));
      rd(ADDR_RECLEN, rv);
      chk(rv, {8'h0, HIRES_REC_LIMIT});
      $display("record clamp test done");
   endtask : t_clamp

   task automatic t_runhalt();
      wr(ADDR_MODE, mw(ACQ_SAMPLE, STOP_RUNHALT, 1'b0, 1'b0, 3'h1));
      pulse(5, 1);
      chk(acq_now(), 32'h1);
      capture_seen = 0;
      pulse(3, 3);
      chk(32'(capture_seen), 32'h3);
      pulse(5, 1);
      chk(acq_now(), 32'h0);
      rd(ADDR_ACQCNT, rv);
      chk(rv, 32'h3);
      pulse(5, 1);
      rd(ADDR_ACQCNT, rv);
      chk(rv, 32'h0);
      pulse(5, 1);
      $display("run halt test done");
   endtask : t_runhalt

   task automatic t_single();
      wr(ADDR_MODE, mw(ACQ_SAMPLE, STOP_SINGLE, 1'b0, 1'b0, 3'h1));
      pulse(5, 1);
      chk(acq_now(), 32'h1);
      pulse(3, 1);
      chk(acq_now(), 32'h0);
      wr(ADDR_COUNT, 32'h3);
      wr(ADDR_MODE, mw(ACQ_AVERAGE, STOP_SINGLE, 1'b0, 1'b0, 3'h1));
      pulse(5, 1);
      pulse(3, 2);
      chk(acq_now(), 32'h1);
      pulse(3, 1);
      chk(acq_now(), 32'h0);
      wr(ADDR_TIMEBASE, 32'h0A);
      wr(ADDR_MODE, mw(ACQ_SAMPLE, STOP_SINGLE, 1'b1, 1'b0, 3'h1));
      pulse(5, 1);
      pulse(3, 2);
      chk(acq_now(), 32'h1);
      pulse(2, 1);
      chk(acq_now(), 32'h0);
      wr(ADDR_TIMEBASE, 32'h64);
      wr(ADDR_MODE, mw(ACQ_SAMPLE, STOP_RUNHALT, 1'b0, 1'b0, 3'h1));
      pulse(4, 1);
      rd(ADDR_STATUS, rv);
      chk((rv >> 3) & 32'h3, 32'h1);
      $display("single sequence test done");
   endtask : t_single

   task automatic t_limit();
      slow <= 1'b1;
      wr(ADDR_MODE, mw(ACQ_SAMPLE, STOP_LIMIT, 1'b0, 1'b0, 3'h1));
      pulse(5, 1);
      pulse(1, 1);
      chk(acq_now(), 32'h1);
      wr(ADDR_MODE, mw(ACQ_SAMPLE, STOP_LIMIT, 1'b0, 1'b1, 3'h1));
      pulse(1, 1);
      chk(acq_now(), 32'h0);
      slow <= 1'b0;
      $display("limit stop test done");
   endtask : t_limit

   task automatic t_display();
      wr(ADDR_INTENS, 32'h0000_7F05);
      settle();
      chk({25'h0, text_intensity}, {25'h0, INTENS_MIN});
      chk({25'h0, wave_intensity}, {25'h0, INTENS_MAX});
      wr(ADDR_INTENS, 32'h0000_3250);
      settle();
      chk({18'h0, wave_intensity, text_intensity}, 32'h0000_1950);
      wr(ADDR_MODE, mw(ACQ_SAMPLE, STOP_RUNHALT, 1'b0, 1'b0, 3'h1));
      wr(ADDR_DISPLAY, 32'h11);
      settle();
      chk({31'h0, intens_sample_mark}, 32'h0);
      wr(ADDR_DISPLAY, 32'h21);
      settle();
      chk({31'h0, intens_sample_mark}, 32'h1);
      wr(ADDR_DISPLAY, 32'h11);
      wr(ADDR_TIMEBASE, 32'h0A);
      settle();
      chk({31'h0, intens_sample_mark}, 32'h1);
      wr(ADDR_DISPLAY, 32'h13);
      erase_seen = 0;
      pulse(0, 1);
      chk(32'(erase_seen), 32'h1);
      wr(ADDR_DISPLAY, 32'h14);
      settle();
      expire_seen = 0;
      repeat (PERSIST_TICK_CYC) @(posedge sys_clk);
      chk(32'(expire_seen), 32'h1);
      $display("display settings test done");
   endtask : t_display

   // ======================================================================
   // Main sequence and watchdog
   initial
   begin
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      settle();
      t_reset();
      t_sampling();
      t_clamp();
      t_runhalt();
      t_single();
      t_limit();
      t_display();
      tally_and_finish();
   end

   // Tests take about 25350 cycles, mostly one persistence period
   initial
   begin
      repeat (40000) @(posedge sys_clk);
      bad_count++;
      $display("unexpected timeout at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      tally_and_finish();
   end
endmodule : acqctl_top_test
